//--- pkg/pts_pkg.sv
// package: register map, fields and reset values of the periodic timer
package pts_pkg;
  localparam logic [11:0] OFF_CONTROL   = 12'h000;
  localparam logic [11:0] OFF_PERIOD    = 12'h004;
  localparam logic [11:0] OFF_COUNT     = 12'h008;
  localparam logic [11:0] OFF_IRQ_FLAG  = 12'h00C;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h010;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h014;

  localparam int unsigned POST_LSB   = 3;
  localparam int unsigned POST_MSB   = 6;
  localparam int unsigned RUN_BIT    = 2;
  localparam int unsigned PRE_LSB    = 0;
  localparam int unsigned PRE_MSB    = 1;
  localparam int unsigned MATCH_BIT  = 1;

  localparam logic [7:0] CONTROL_MASK = 8'h7F;
  localparam logic [7:0] IRQ_MASK     = 8'hEF;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] PERIOD_RST   = 8'hFF;
  localparam logic [7:0] COUNT_RST    = 8'h00;
  localparam logic [7:0] IRQ_RST      = 8'h00;

  localparam logic [3:0] PRE_DIV1_LAST  = 4'h0;
  localparam logic [3:0] PRE_DIV4_LAST  = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST = 4'hF;

  typedef struct packed {
    logic [3:0] post_sel;
    logic       run;
    logic [1:0] pre_sel;
  } pts_ctrl_t;
endpackage : pts_pkg

//--- core/pts_prescaler.sv
// input prescaler: one tick every 1, 4 or 16 clocks while running
`timescale 1ns/1ps
module pts_prescaler
  import pts_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [1:0] pre_sel,
  input  wire logic       clear,
  output logic            tick
);
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [3:0] last_count;

  // upper select bit alone picks divide by 16
  assign last_count = pre_sel[1] ? PRE_DIV16_LAST :
                      (pre_sel[0] ? PRE_DIV4_LAST : PRE_DIV1_LAST);
  assign tick     = run && (div_reg >= last_count);
  assign div_next = (clear || !run || tick) ? 4'h0 : div_reg + 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_next;
    end
  end
endmodule : pts_prescaler

//--- core/pts_timer.sv
// periodic timer with prescaler, period match and postscaler, APB slave
// How it works
// - The output divide select field in control bits 6:3 sets a postscaler ratio of value+1.
// - The input divide select in bits 1:0 divides by 1 for 00, 4 for 01 and 16 for 1x.
// - The count value is an 8-bit read/write register that resets to zero.
// - The match flag is flag bit 1 and its enable is enable bit 1, both cleared on reset.
// - Control bit 7 and flag/enable bit 4 read as zero and ignore writes.
// - The control register resets to zero so the timer starts stopped at 1:1 ratios.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pts_timer
  import pts_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  logic [7:0] control_reg;
  logic [7:0] period_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] enable_reg;
  logic [3:0] post_reg;
  logic [3:0] post_next;
  logic [31:0] rdata_next;

  pts_ctrl_t  ctrl;
  logic       wr_en;
  logic       rd_en;
  logic       lane0;
  logic       hit_control;
  logic       hit_period;
  logic       hit_count;
  logic       hit_flag;
  logic       hit_enable;
  logic       hit_clear;
  logic       mapped;
  logic       tick;
  logic       period_match;
  logic       post_wrap;
  logic [7:0] clear_bits;
  logic [7:0] wbyte;
  logic       pre_clear;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  // bus decode; every access completes in the first access cycle
  assign pready      = 1'b1;
  assign wr_en       = psel && penable && pwrite;
  assign rd_en       = psel && !penable && !pwrite;
  assign lane0       = pstrb[0];
  assign pre_clear   = wr_en && lane0 && (hit_count || hit_control);
  assign wbyte       = pwdata[7:0];
  assign hit_control = addr_is(paddr, OFF_CONTROL);
  assign hit_period  = addr_is(paddr, OFF_PERIOD);
  assign hit_count   = addr_is(paddr, OFF_COUNT);
  assign hit_flag    = addr_is(paddr, OFF_IRQ_FLAG);
  assign hit_enable  = addr_is(paddr, OFF_IRQ_EN);
  assign hit_clear   = addr_is(paddr, OFF_IRQ_CLEAR);
  assign mapped      = hit_control | hit_period | hit_count | hit_flag | hit_enable | hit_clear;
  // unmapped addresses answer with an error; clear register is write-only
  assign pslverr     = psel && penable && (!mapped || (!pwrite && hit_clear));

  assign ctrl = pts_ctrl_t'(control_reg[POST_MSB:PRE_LSB]);

  pts_prescaler u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ctrl.run),
    .pre_sel (ctrl.pre_sel),
    .clear   (pre_clear),
    .tick    (tick)
  );

  assign period_match = tick && (count_reg == period_reg);
  assign post_wrap    = period_match && (post_reg == ctrl.post_sel);

  // a software write to the count wins over the running count
  assign count_next = (wr_en && lane0 && hit_count) ? wbyte :
                      period_match ? 8'h00 :
                      tick ? count_reg + 8'h01 : count_reg;
  assign post_next  = pre_clear ? 4'h0 :
                      post_wrap ? 4'h0 :
                      period_match ? post_reg + 4'h1 : post_reg;

  assign clear_bits = (wr_en && lane0 && hit_clear) ? wbyte : 8'h00;
  // hardware set wins over a clear in the same cycle
  assign flag_next  = ((flag_reg & ~clear_bits) |
                      ({7'h00, post_wrap} << MATCH_BIT)) & IRQ_MASK;

  assign irq = |(flag_reg & enable_reg);

  assign rdata_next = hit_control ? {24'h0, control_reg} :
                      hit_period  ? {24'h0, period_reg} :
                      hit_count   ? {24'h0, count_reg} :
                      hit_flag    ? {24'h0, flag_reg} :
                      hit_enable  ? {24'h0, enable_reg} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= CONTROL_RST;
      period_reg  <= PERIOD_RST;
      enable_reg  <= IRQ_RST;
    end else if (wr_en && lane0) begin
      if (hit_control) begin
        control_reg <= wbyte & CONTROL_MASK;
      end
      if (hit_period) begin
        period_reg <= wbyte;
      end
      if (hit_enable) begin
        enable_reg <= wbyte & IRQ_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= COUNT_RST;
      post_reg  <= 4'h0;
      flag_reg  <= IRQ_RST;
    end else begin
      count_reg <= count_next;
      post_reg  <= post_next;
      flag_reg  <= flag_next;
    end
  end

  // read data captured in setup so it is stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rdata_next;
    end
  end

  // check-side helpers; they follow the ratios, not the datapath compare
  logic [4:0] gap_reg;
  logic [4:0] gap_next;
  logic [4:0] matches_reg;
  logic [4:0] matches_next;
  logic       count_load;
  logic       period_load;
  logic       control_load;
  logic       enable_load;
  logic       clear_match;

  function automatic logic [4:0] ratio_last(input logic [1:0] sel);
    ratio_last = sel[1] ? {1'b0, PRE_DIV16_LAST} :
                 (sel[0] ? {1'b0, PRE_DIV4_LAST} : {1'b0, PRE_DIV1_LAST});
  endfunction : ratio_last

  assign count_load   = wr_en && lane0 && hit_count;
  assign period_load  = wr_en && lane0 && hit_period;
  assign control_load = wr_en && lane0 && hit_control;
  assign enable_load  = wr_en && lane0 && hit_enable;
  assign clear_match  = wr_en && lane0 && hit_clear && wbyte[MATCH_BIT];

  // saturates, so a stuck divider cannot wrap back into a legal gap
  assign gap_next     = (pre_clear || !ctrl.run || tick) ? 5'h00 :
                        (gap_reg == 5'h1F) ? gap_reg : gap_reg + 5'h01;
  assign matches_next = (pre_clear || post_wrap) ? 5'h00 :
                        period_match ? matches_reg + 5'h01 : matches_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg     <= 5'h00;
      matches_reg <= 5'h00;
    end else begin
      gap_reg     <= gap_next;
      matches_reg <= matches_next;
    end
  end

  sequence match_seen_s;
    post_wrap;
  endsequence

  sequence count_load_s;
    count_load;
  endsequence

  sequence plain_tick_s;
    tick && !period_match && !count_load;
  endsequence

  sequence stopped_s;
    !ctrl.run && !count_load;
  endsequence

  sequence flag_kept_s;
    flag_reg[MATCH_BIT] && !clear_match;
  endsequence

  sequence flag_cleared_s;
    clear_match && !post_wrap;
  endsequence

  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    match_seen_s |=> flag_reg[MATCH_BIT])
    else $error("match flag not set");

  count_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_match && !count_load |=> count_reg == 8'h00)
    else $error("count not cleared on period match");

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    plain_tick_s |=> count_reg == $past(count_reg) + 8'h01)
    else $error("count did not advance on tick");

  hold_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    stopped_s |=> $stable(count_reg))
    else $error("count moved while stopped");

  no_tick_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.run |-> !tick)
    else $error("prescaler ticked while stopped");

  div16_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.run && ctrl.pre_sel[1] |-> tick == (gap_reg == {1'b0, PRE_DIV16_LAST}))
    else $error("divide by 16 tick spacing wrong");

  tick_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.run && tick |-> gap_reg == ratio_last(ctrl.pre_sel))
    else $error("prescaler ticked early");

  tick_due_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.run && gap_reg == ratio_last(ctrl.pre_sel) |-> tick)
    else $error("prescaler tick missing");

  unimpl_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    control_reg[7] == 1'b0)
    else $error("control bit 7 set");

  unimpl_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag_reg[4] == 1'b0 && enable_reg[4] == 1'b0)
    else $error("interrupt bit 4 set");

  post_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_match |-> post_wrap == (matches_reg == {1'b0, ctrl.post_sel}))
    else $error("postscaler ratio wrong");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag_reg[MATCH_BIT] && enable_reg[MATCH_BIT] |-> irq)
    else $error("interrupt not raised");

  irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(flag_reg[MATCH_BIT] && enable_reg[MATCH_BIT]) |-> !irq)
    else $error("interrupt raised without enabled flag");

  count_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    count_load_s |=> count_reg == $past(wbyte))
    else $error("count write lost");

  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag_kept_s |=> flag_reg[MATCH_BIT])
    else $error("match flag dropped without clear");

  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    flag_cleared_s |=> !flag_reg[MATCH_BIT])
    else $error("match flag not cleared");

  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    control_load |=> control_reg == ($past(wbyte) & CONTROL_MASK))
    else $error("control write wrong");

  period_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_load |=> period_reg == $past(wbyte))
    else $error("period write lost");

  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    enable_load |=> enable_reg == ($past(wbyte) & IRQ_MASK))
    else $error("enable write wrong");

  // read data is captured in setup, so it is looked at one edge later
  read_spare_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit_control |=> !prdata[7])
    else $error("control bit 7 read as one");

  read_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && (hit_flag || hit_enable) |=> !prdata[4])
    else $error("interrupt bit 4 read as one");

  // only the match bit of the flag register has a source here
  for (genvar b = 0; b < 8; b++) begin : g_spare
    if (b != MATCH_BIT) begin : g_bit
      spare_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        !flag_reg[b])
        else $error("spare flag bit set");
    end
  end
endmodule : pts_timer

//--- bench/pts_testbench.sv
// self-checking bench for the periodic timer: registers, scalers, interrupt
`timescale 1ns/1ps
module testbench;
  import pts_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          seed = 32'h9719;

  always #2 pclk = ~pclk;

  pts_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask : chk

  // one transfer, idle cycle after so strobes never change twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pstrb <= st;
    pwdata <= {8'h5A, 16'($random(seed)), d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; conclude(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, 4'hF, r, e);
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, 4'hF, r, e);
    chk(what, r, {24'h0, exp});
    chk({what, "_err"}, {31'h0, e}, 32'h0);
  endtask : rdc

  function automatic int exp_cyc(logic [7:0] per, logic [1:0] pre, logic [3:0] post);
    int div;
    div = (pre == 2'b00) ? 1 : (pre == 2'b01) ? 4 : 16;
    return (int'(per) + 1) * div * (int'(post) + 1);
  endfunction : exp_cyc

  initial begin
    repeat (90000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  per;
    logic [3:0]  post;
    logic [1:0]  pre;
    int          n;
    int          x;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("control_rst", OFF_CONTROL, 8'h00);
    rdc("period_rst", OFF_PERIOD, 8'hFF);
    rdc("count_rst", OFF_COUNT, 8'h00);
    rdc("flag_rst", OFF_IRQ_FLAG, 8'h00);
    rdc("enable_rst", OFF_IRQ_EN, 8'h00);
    wr(OFF_IRQ_EN, 8'hFF);
    rdc("enable_mask", OFF_IRQ_EN, 8'hEF);
    // run stays 0 so the written count must hold
    wr(OFF_CONTROL, 8'hFB);
    rdc("control_mask", OFF_CONTROL, 8'h7B);
    per = 8'($random(seed));
    wr(OFF_COUNT, per);
    repeat (20) @(posedge pclk);
    rdc("count_hold", OFF_COUNT, per);
    apb(1'b1, OFF_PERIOD, 8'h12, 4'h0, r, e);
    rdc("strobe_off", OFF_PERIOD, 8'hFF);
    apb(1'b0, 12'h018, 8'h00, 4'hF, r, e);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    // every prescale code, random periods, full 1:16 postscale as corner
    for (int i = 0; i < 5; i++) begin
      pre = i[1:0];
      post = (i == 4) ? 4'hF : 4'($random(seed) & 3);
      per = 8'(($random(seed) & 7) + 1);
      wr(OFF_IRQ_EN, 8'h02);
      wr(OFF_PERIOD, per);
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CONTROL, {1'b0, post, 1'b1, pre});
      n = 1;
      while (irq !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
      x = exp_cyc(per, pre, post);
      chk("match_time", 32'(n >= x - 1 && n <= x + 2), 32'h1);
      wr(OFF_CONTROL, 8'h00);
      rdc("flag_set", OFF_IRQ_FLAG, 8'h02);
      wr(OFF_IRQ_CLEAR, 8'h02);
      rdc("flag_clear", OFF_IRQ_FLAG, 8'h00);
      chk("irq_clear", {31'h0, irq}, 32'h0);
    end
    // masked: flag still sets but the line stays low
    wr(OFF_IRQ_EN, 8'h00);
    wr(OFF_CONTROL, 8'h04);
    repeat (600) @(posedge pclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(OFF_CONTROL, 8'h00);
    rdc("flag_masked", OFF_IRQ_FLAG, 8'h02);
    // period 0 at 1:1 wraps every clock, so a clear meets a set
    wr(OFF_PERIOD, 8'h00);
    wr(OFF_CONTROL, 8'h04);
    wr(OFF_IRQ_CLEAR, 8'h02);
    rdc("set_over_clear", OFF_IRQ_FLAG, 8'h02);
    apb(1'b0, OFF_IRQ_CLEAR, 8'h00, 4'hF, r, e);
    chk("clear_rd_err", {31'h0, e}, 32'h1);
    chk("clear_rd_data", r, 32'h0);
    // reset in mid-run with the line raised
    wr(OFF_IRQ_EN, 8'h02);
    chk("irq_enabled", {31'h0, irq}, 32'h1);
    wr(OFF_CONTROL, 8'h7F);
    repeat (40) @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("irq_in_reset", {31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("control_rst2", OFF_CONTROL, 8'h00);
    rdc("period_rst2", OFF_PERIOD, 8'hFF);
    rdc("count_rst2", OFF_COUNT, 8'h00);
    rdc("flag_rst2", OFF_IRQ_FLAG, 8'h00);
    rdc("enable_rst2", OFF_IRQ_EN, 8'h00);
    conclude();
  end
endmodule : testbench
